// ==== core/ovr_pkg.sv ====
// Shared constants and types of the local override block
`default_nettype none
package ovr_pkg;
	// Structure
	localparam int NUM_POINTS = 4;
	localparam int VAL_W = 8;
	localparam int PTR_W = 2;
	// Value stepping
	localparam logic [7:0] VAL_MIN = 8'h00;
	localparam logic [7:0] VAL_MAX = 8'hFF;
	localparam logic [7:0] VAL_STEP = 8'h10;
	localparam logic [7:0] VAL_RST = 8'h00;
	// Button bit positions inside btn_t
	localparam int BTN_MINUS = 0;
	localparam int BTN_PLUS = 1;
	localparam int BTN_CENTRE = 2;
	// Timing, clock rate in MHz and times in microseconds
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned DEBOUNCE_US = 10000;
	localparam int unsigned HOLD_US = 1000000;
	localparam int unsigned RPT_DLY_US = 500000;
	localparam int unsigned RPT_US = 200000;
	localparam logic [31:0] DEBOUNCE_CYC = 32'(DEBOUNCE_US * CLK_MHZ);
	localparam logic [31:0] HOLD_CYC = 32'(HOLD_US * CLK_MHZ);
	localparam logic [31:0] RPT_DLY_CYC = 32'(RPT_DLY_US * CLK_MHZ);
	localparam logic [31:0] RPT_CYC = 32'(RPT_US * CLK_MHZ);
	// Types
	typedef logic [VAL_W-1:0] value_t;
	typedef value_t [NUM_POINTS-1:0] vals_t;
	typedef logic [NUM_POINTS-1:0] pmask_t;
	typedef logic [PTR_W-1:0] ptr_t;
	typedef struct packed {
		logic centre;
		logic plus;
		logic minus;
	} btn_t;
	typedef btn_t [NUM_POINTS-1:0] btns_t;
	typedef struct packed {
		logic ovr;
		value_t val;
	} entry_t;
	typedef struct packed {
		logic valid;
		ptr_t point;
		logic ovr;
		value_t val;
	} report_t;
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic [31:0] cnt;
		logic [31:0] tmr;
		logic fired;
		logic ev;
	} fstate_t;
endpackage
`default_nettype wire

// ==== core/ovr_store.sv ====
// Retained per-point override state and value, registered read port
`default_nettype none
module ovr_store (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Write port
	input wire logic wrEn,
	input wire ovr_pkg::ptr_t wrAddr,
	input wire ovr_pkg::entry_t wrData,
	// Read port, data one cycle after address
	input wire ovr_pkg::ptr_t rdAddr,
	output ovr_pkg::entry_t rdData
);
	import ovr_pkg::*;

	typedef struct packed {
		entry_t [NUM_POINTS-1:0] mem;
		entry_t rd;
	} mstate_t;

	mstate_t st_r;
	mstate_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Next state: write, then registered read of the old contents
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd = st_r.mem[rdAddr];
		if (wrEn) begin
			st_nxt.mem[wrAddr] = wrData;
		end
	end

	// Array is not cleared by reset so that it keeps its contents
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
		if (sys_rst) begin
			st_r.rd <= '0;
		end
	end

	assign rdData = st_r.rd;
endmodule
`default_nettype wire

// ==== core/button_filter.sv ====
// Synchroniser, debounce, hold and repeat timers for one point's buttons
`default_nettype none
module button_filter #(
	parameter logic [31:0] DEB_CYC = ovr_pkg::DEBOUNCE_CYC,
	parameter logic [31:0] HOLD_CYC = ovr_pkg::HOLD_CYC,
	parameter logic [31:0] RPT_DLY_CYC = ovr_pkg::RPT_DLY_CYC,
	parameter logic [31:0] RPT_CYC = ovr_pkg::RPT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Raw button pins, high while pressed
	input wire ovr_pkg::btn_t btnRaw,
	// One-cycle events
	output ovr_pkg::btn_t evOut
);
	import ovr_pkg::*;

	genvar b;
	generate
		for (b = 0; b < 3; b++) begin : g_btn
			fstate_t st_r;
			fstate_t st_nxt;

			// Debounce needs a stable level for DEB_CYC, then timing
			always_comb begin
				st_nxt = st_r;
				st_nxt.sync = {st_r.sync[1:0], btnRaw[b]};
				st_nxt.ev = 1'b0;
				if (st_r.sync[2] != st_r.level &&
				    st_r.sync[1] == st_r.sync[2]) begin
					st_nxt.cnt = st_r.cnt + 32'h1;
					if (st_r.cnt >= DEB_CYC - 32'h1) begin
						st_nxt.level = st_r.sync[2];
						st_nxt.cnt = '0;
						st_nxt.tmr = '0;
						st_nxt.fired = 1'b0;
						// Step buttons act at the press itself
						st_nxt.ev = st_r.sync[2] && b != BTN_CENTRE;
					end
				end else begin
					st_nxt.cnt = '0;
					if (st_r.level) begin
						st_nxt.tmr = st_r.tmr + 32'h1;
						if (b == BTN_CENTRE) begin
							// One toggle per press, after the hold time
							if (!st_r.fired && st_r.tmr == HOLD_CYC - 32'h1) begin
								st_nxt.ev = 1'b1;
								st_nxt.fired = 1'b1;
							end
						end else if (!st_r.fired &&
						             st_r.tmr == RPT_DLY_CYC - 32'h1) begin
							st_nxt.ev = 1'b1;
							st_nxt.fired = 1'b1;
							st_nxt.tmr = '0;
						end else if (st_r.fired &&
						             st_r.tmr == RPT_CYC - 32'h1) begin
							st_nxt.ev = 1'b1;
							st_nxt.tmr = '0;
						end
					end
				end
			end

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					st_r <= '0;
				end else begin
					st_r <= st_nxt;
				end
			end

			assign evOut[b] = st_r.ev;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== core/io_point_local_override.sv ====
// Local manual override of the I/O points of one module
//
// Functional notes
// - Override only on output points; attempts on inputs give an error.
// - Works without bus manager when supply is good and key inserted.
// - Entering override holds the output at its last value.
// - Leaving override returns the output to the station's value.
// - Report each override and value; keep them in retained storage.
// - Configuration bit from controller blocks entering override.
// - Override changes act at once, no interlock gates them.
// - Centre button toggles override, taking effect while still held.
// - Plus in override raises value one step or turns relay on.
// - Minus in override lowers value one step or turns relay off.
// - Repeated or held steps continue and saturate at the end stages.
// - Status LED and LCD follow every override value change.
// - Plus or minus outside override gives error, value unchanged.
// - Yellow LED off in automatic, on while in local override.
// - Grouped points light together and accept input from any member.
// - Source priority: local, tool, function test, automatic.
`default_nettype none
module io_point_local_override #(
	parameter logic [31:0] DEB_CYC = ovr_pkg::DEBOUNCE_CYC,
	parameter logic [31:0] HOLD_CYC = ovr_pkg::HOLD_CYC,
	parameter logic [31:0] RPT_DLY_CYC = ovr_pkg::RPT_DLY_CYC,
	parameter logic [31:0] RPT_CYC = ovr_pkg::RPT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Button pins per point
	input wire ovr_pkg::btns_t btnRaw,
	// Point configuration from the controller
	input wire ovr_pkg::pmask_t isOutput,
	input wire ovr_pkg::pmask_t isRelay,
	input wire ovr_pkg::pmask_t groupMask,
	input wire logic ovrDisable,
	input wire logic restoreEn,
	// Supply and address key pins
	input wire logic supplyOk,
	input wire logic addrKeyIn,
	// Lower priority value sources
	input wire ovr_pkg::vals_t autoVal,
	input wire ovr_pkg::pmask_t toolEn,
	input wire ovr_pkg::vals_t toolVal,
	input wire ovr_pkg::pmask_t testEn,
	input wire ovr_pkg::vals_t testVal,
	// Point outputs and indications
	output ovr_pkg::vals_t outValue,
	output ovr_pkg::pmask_t ovrLed,
	output ovr_pkg::pmask_t statusLed,
	output ovr_pkg::vals_t lcdValue,
	output ovr_pkg::pmask_t lcdUpdate,
	output ovr_pkg::pmask_t errInd,
	// Report towards the bus manager
	output ovr_pkg::report_t report
);
	import ovr_pkg::*;

	typedef enum logic [2:0] {
		ST_RD_REQ = 3'b001,
		ST_RD_LOAD = 3'b010,
		ST_RUN = 3'b100
	} phase_t;

	typedef struct packed {
		phase_t phase;
		ptr_t ptr;
		logic [2:0] supSync;
		logic [2:0] keySync;
		logic supOk;
		logic keyOk;
		pmask_t ovr;
		vals_t val;
		pmask_t dirty;
		vals_t outVal;
		pmask_t led;
		pmask_t stLed;
		vals_t lcd;
		pmask_t lcdUpd;
		pmask_t err;
		report_t rep;
	} tstate_t;

	tstate_t st_r;
	tstate_t st_nxt;
	btns_t ev;
	entry_t rdData;
	logic wrEn;
	ptr_t wrAddr;
	entry_t wrData;

	////////////////////////////////////////////////////////////////////////
	// Button conditioning per point
	genvar p;
	generate
		for (p = 0; p < NUM_POINTS; p++) begin : g_pt
			button_filter #(
				.DEB_CYC(DEB_CYC),
				.HOLD_CYC(HOLD_CYC),
				.RPT_DLY_CYC(RPT_DLY_CYC),
				.RPT_CYC(RPT_CYC)
			) u_filter (
				.clk(clk),
				.sys_rst(sys_rst),
				.btnRaw(btnRaw[p]),
				.evOut(ev[p])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Retained storage of override state
	ovr_store u_store (
		.clk(clk),
		.sys_rst(sys_rst),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.rdAddr(st_r.ptr),
		.rdData(rdData)
	);

	////////////////////////////////////////////////////////////////////////
	// Override decisions, source selection, storage and reporting
	always_comb begin
		logic gTog;
		logic gPlus;
		logic gMinus;
		logic tog;
		logic up;
		logic dn;
		logic allowed;
		logic found;
		value_t nv;
		gTog = 1'b0;
		gPlus = 1'b0;
		gMinus = 1'b0;
		tog = 1'b0;
		up = 1'b0;
		dn = 1'b0;
		allowed = 1'b0;
		found = 1'b0;
		nv = '0;
		wrEn = 1'b0;
		wrAddr = '0;
		wrData = '0;
		st_nxt = st_r;
		st_nxt.err = '0;
		st_nxt.lcdUpd = '0;
		st_nxt.rep.valid = 1'b0;

		// Pins are accepted once second and third stage agree
		// Loss of supply or key blocks entry and steps but keeps an override; leaving still works
		st_nxt.supSync = {st_r.supSync[1:0], supplyOk};
		st_nxt.keySync = {st_r.keySync[1:0], addrKeyIn};
		if (st_r.supSync[1] == st_r.supSync[2]) begin
			st_nxt.supOk = st_r.supSync[2];
		end
		if (st_r.keySync[1] == st_r.keySync[2]) begin
			st_nxt.keyOk = st_r.keySync[2];
		end
		// No bus manager signal enters here on purpose
		allowed = st_r.supOk && st_r.keyOk;

		// A group acts as one function: any member's button drives all
		for (int i = 0; i < NUM_POINTS; i++) begin
			gTog = gTog | (ev[i].centre & groupMask[i]);
			gPlus = gPlus | (ev[i].plus & groupMask[i]);
			gMinus = gMinus | (ev[i].minus & groupMask[i]);
		end

		case (st_r.phase)
			ST_RD_REQ: begin
				// The store read is registered, so each entry takes two cycles
				// Read of entry ptr is under way
				st_nxt.phase = ST_RD_LOAD;
				if (!restoreEn) begin
					// Nothing retained: start clean and write back
					st_nxt.ovr = '0;
					st_nxt.val = '0;
					st_nxt.dirty = '1;
					st_nxt.phase = ST_RUN;
				end
			end
			ST_RD_LOAD: begin
				st_nxt.ovr[st_r.ptr] = rdData.ovr & isOutput[st_r.ptr];
				st_nxt.val[st_r.ptr] = rdData.val;
				st_nxt.dirty[st_r.ptr] = 1'b1; // Report restored state
				st_nxt.ptr = st_r.ptr + 2'h1;
				st_nxt.phase = ST_RD_REQ;
				if (st_r.ptr == PTR_W'(NUM_POINTS - 1)) begin
					st_nxt.phase = ST_RUN;
				end
			end
			ST_RUN: begin
				// Lowest dirty point is stored and reported first
				// One store write per cycle; later dirty points wait their turn
				for (int i = 0; i < NUM_POINTS; i++) begin
					if (st_r.dirty[i] && !found) begin
						found = 1'b1;
						wrEn = 1'b1;
						wrAddr = PTR_W'(i);
						wrData.ovr = st_r.ovr[i];
						wrData.val = st_r.val[i];
						st_nxt.dirty[i] = 1'b0;
						st_nxt.rep.valid = 1'b1;
						st_nxt.rep.point = PTR_W'(i);
						st_nxt.rep.ovr = st_r.ovr[i];
						st_nxt.rep.val = st_r.val[i];
					end
				end
				// Changes act in this cycle, no interlock involved
				for (int i = 0; i < NUM_POINTS; i++) begin
					tog = groupMask[i] ? gTog : ev[i].centre;
					up = groupMask[i] ? gPlus : ev[i].plus;
					dn = groupMask[i] ? gMinus : ev[i].minus;
					if (tog) begin
						if (!isOutput[i]) begin
							st_nxt.err[i] = 1'b1;
						end else if (st_r.ovr[i]) begin
							st_nxt.ovr[i] = 1'b0;
							st_nxt.dirty[i] = 1'b1;
						end else if (ovrDisable || !allowed) begin
							st_nxt.err[i] = 1'b1;
						end else begin
							st_nxt.ovr[i] = 1'b1;
							st_nxt.val[i] = st_r.outVal[i];
							st_nxt.dirty[i] = 1'b1;
						end
					end else if (up || dn) begin
						if (!isOutput[i]) begin
							st_nxt.err[i] = 1'b1;
						end else if (!st_r.ovr[i] || !allowed) begin
							st_nxt.err[i] = 1'b1;
						end else begin
							nv = st_r.val[i];
							if (up && isRelay[i]) begin
								nv = VAL_MAX;
							end else if (up) begin
								// Saturate at the top stage
								nv = (st_r.val[i] > VAL_MAX - VAL_STEP) ?
								     VAL_MAX : st_r.val[i] + VAL_STEP;
							end else if (isRelay[i]) begin
								nv = VAL_MIN;
							end else begin
								nv = (st_r.val[i] < VAL_MIN + VAL_STEP) ?
								     VAL_MIN : st_r.val[i] - VAL_STEP;
							end
							st_nxt.val[i] = nv;
							if (nv != st_r.val[i]) begin
								st_nxt.dirty[i] = 1'b1;
							end
						end
					end
				end
			end
			default: begin
				st_nxt.phase = ST_RD_REQ;
				st_nxt.ptr = '0;
			end
		endcase

		// Output source priority and indications
		// Taken from st_nxt so indications leave the flops with the value
		for (int i = 0; i < NUM_POINTS; i++) begin
			if (st_nxt.ovr[i]) begin
				st_nxt.outVal[i] = st_nxt.val[i];
			end else if (toolEn[i]) begin
				st_nxt.outVal[i] = toolVal[i];
			end else if (testEn[i]) begin
				st_nxt.outVal[i] = testVal[i];
			end else begin
				st_nxt.outVal[i] = autoVal[i];
			end
			st_nxt.led[i] = st_nxt.ovr[i];
			st_nxt.stLed[i] = st_nxt.outVal[i] != VAL_MIN;
			st_nxt.lcd[i] = st_nxt.outVal[i];
			st_nxt.lcdUpd[i] = st_nxt.outVal[i] != st_r.outVal[i];
		end
	end

	// All state in one register
	// Phase gets its one-hot start code, never the all-zero word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.phase <= ST_RD_REQ;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign outValue = st_r.outVal;
	assign ovrLed = st_r.led;
	assign statusLed = st_r.stLed;
	assign lcdValue = st_r.lcd;
	assign lcdUpdate = st_r.lcdUpd;
	assign errInd = st_r.err;
	assign report = st_r.rep;
endmodule
`default_nettype wire

// ==== verif/bus_manager_model.sv ====
// Bus manager stand-in that collects the override reports
`default_nettype none
module bus_manager_model
	import ovr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Report from the block
	input wire ovr_pkg::report_t report,
	// Last reported state per point
	output ovr_pkg::vals_t lastVal,
	output ovr_pkg::pmask_t lastOvr,
	output logic [7:0] nReport
);
	timeunit 1ns;
	timeprecision 1ps;
	// Latch every report; the count shows the start-up burst
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lastVal <= '0;
			lastOvr <= '0;
			nReport <= 8'h00;
		end else if (report.valid) begin
			lastVal[report.point] <= report.val;
			lastOvr[report.point] <= report.ovr;
			nReport <= nReport + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verif/io_point_local_override_sva.sv ====
// Port-level assertions of the local override block
`default_nettype none
module io_point_local_override_sva
	import ovr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Watched inputs
	input wire ovr_pkg::pmask_t isOutput,
	input wire logic ovrDisable,
	input wire ovr_pkg::pmask_t toolEn,
	input wire ovr_pkg::pmask_t testEn,
	input wire ovr_pkg::vals_t autoVal,
	input wire ovr_pkg::vals_t toolVal,
	input wire ovr_pkg::vals_t testVal,
	// Watched outputs
	input wire ovr_pkg::vals_t outValue,
	input wire ovr_pkg::pmask_t ovrLed,
	input wire ovr_pkg::pmask_t statusLed,
	input wire ovr_pkg::vals_t lcdValue,
	input wire ovr_pkg::pmask_t lcdUpdate,
	input wire ovr_pkg::pmask_t errInd,
	input wire ovr_pkg::report_t report
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] up_r;
	// One clock domain only
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////
	// Settling counter, keeps the init phase out of the source check
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			up_r <= 4'h0;
		end else if (up_r != 4'hF) begin
			up_r <= up_r + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Indications follow the output value
	a_lcd_mirror: assert property (lcdValue == outValue)
		else $error("lcd value differs from output");
	a_status_led: assert property (
		statusLed[0] == (outValue[0] != 8'h00))
		else $error("status led wrong");
	a_update_pulse: assert property (up_r != 4'h0 |->
		lcdUpdate[0] == (outValue[0] != $past(outValue[0])))
		else $error("lcd update pulse wrong");
	// Entry conditions and behaviour
	a_input_refused: assert property (!isOutput[2] && !ovrLed[2] |=>
		!ovrLed[2])
		else $error("override entered on input");
	a_entry_blocked: assert property ($rose(ovrLed[0]) |->
		!$past(ovrDisable))
		else $error("override entered while disabled");
	// Restore after reset may light the led with a stored value
	a_entry_holds: assert property (up_r == 4'hF &&
		$rose(ovrLed[0]) |-> $stable(outValue[0]))
		else $error("output jumped on entry");
	a_err_no_change: assert property (errInd[3] && ovrLed[3] |->
		$stable(outValue[3]))
		else $error("refused press changed value");
	// Priority among lower sources while not overridden
	a_source_order: assert property (!ovrLed[0] && up_r == 4'hF |->
		outValue[0] == ($past(toolEn[0]) ? $past(toolVal[0]) :
		$past(testEn[0]) ? $past(testVal[0]) : $past(autoVal[0])))
		else $error("wrong output source");
	a_report_entry: assert property ($rose(ovrLed[0]) |-> ##[1:8]
		(report.valid && report.point == 2'h0 && report.ovr))
		else $error("override entry not reported");
	// Main scenarios
	c_enter: cover property ($rose(ovrLed[0]));
	c_err_input: cover property (errInd[2]);
	c_sat: cover property (ovrLed[0] && outValue[0] == 8'hFF);
endmodule
`default_nettype wire

// ==== verif/test_io_point_local_override.sv ====
// Self-checking bench of the local override block
`default_nettype none
module test_io_point_local_override;
	timeunit 1ns;
	timeprecision 1ps;
	import ovr_pkg::*;
	logic clk, sys_rst, ovrDisable, restoreEn, supplyOk, addrKeyIn;
	logic errClr;
	btns_t btnRaw;
	pmask_t isOutput, isRelay, groupMask, toolEn, testEn, errSeen;
	pmask_t ovrLed, statusLed, lcdUpdate, errInd, lastOvr;
	vals_t autoVal, toolVal, testVal, outValue, lcdValue, lastVal;
	report_t report;
	logic [7:0] nReport;
	int n_mismatch, n_compared, seed, cyc;
	////////////////////////////////////////////////////////////////////////
	// Short counts keep the run brief
	io_point_local_override #(.DEB_CYC(32'h4), .HOLD_CYC(32'h14),
		.RPT_DLY_CYC(32'h10), .RPT_CYC(32'h8)) i_dut (.clk(clk),
		.sys_rst(sys_rst), .btnRaw(btnRaw), .isOutput(isOutput),
		.isRelay(isRelay), .groupMask(groupMask), .ovrDisable(ovrDisable),
		.restoreEn(restoreEn), .supplyOk(supplyOk), .addrKeyIn(addrKeyIn),
		.autoVal(autoVal), .toolEn(toolEn), .toolVal(toolVal),
		.testEn(testEn), .testVal(testVal), .outValue(outValue),
		.ovrLed(ovrLed), .statusLed(statusLed), .lcdValue(lcdValue),
		.lcdUpdate(lcdUpdate), .errInd(errInd), .report(report));
	bus_manager_model i_bm (.clk(clk), .sys_rst(sys_rst), .report(report),
		.lastVal(lastVal), .lastOvr(lastOvr), .nReport(nReport));
	// Clock, error catcher and hang guard
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (sys_rst || errClr) begin
			errSeen <= '0;
		end else begin
			errSeen <= errSeen | errInd;
		end
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Error pulses are caught by errSeen, cleared at each press
	task automatic press(input int p, b, n);
		errClr = 1'b1;
		@(negedge clk);
		errClr = 1'b0;
		btnRaw[p][b] = 1'b1;
		repeat (n) @(negedge clk);
		btnRaw[p][b] = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	task automatic tdone(input string nm);
		$display("done: %s", nm);
	endtask
	function automatic logic [7:0] prio(input int p);
		return toolEn[p] ? toolVal[p] : testEn[p] ? testVal[p] : autoVal[p];
	endfunction
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 7428;
		sys_rst = 1'b1;
		btnRaw = '0;
		isOutput = 4'hB;
		isRelay = 4'h8;
		groupMask = 4'h0;
		{ovrDisable, restoreEn, supplyOk, addrKeyIn} = 4'h3;
		{autoVal, toolVal, testVal, toolEn, testEn} = '0;
		errClr = 1'b0;
		repeat (10) @(negedge clk);
		chk("reset leds", ovrLed, 4'h0);
		sys_rst = 1'b0;
		repeat (12) @(negedge clk);
		chk("start reports", nReport, 8'h04);
		for (int i = 0; i < 24; i++) begin
			autoVal = $random(seed);
			toolVal = $random(seed);
			testVal = $random(seed);
			toolEn = 4'($random(seed));
			testEn = 4'($random(seed));
			repeat (2) @(negedge clk);
			for (int p = 0; p < 4; p++) begin
				chk("source", outValue[p], prio(p));
				chk("status", statusLed[p], prio(p) != 8'h00);
			end
		end
		tdone("priority");
		{toolEn, testEn} = '0;
		autoVal = 32'h20003040;
		press(0, BTN_PLUS, 12);
		chk("idle err", errSeen[0], 1'b1);
		chk("idle val", outValue[0], 8'h40);
		press(2, BTN_CENTRE, 40);
		chk("input err", errSeen[2], 1'b1);
		chk("input led", ovrLed[2], 1'b0);
		ovrDisable = 1'b1;
		press(0, BTN_CENTRE, 40);
		chk("off err", errSeen[0], 1'b1);
		chk("off led", ovrLed[0], 1'b0);
		ovrDisable = 1'b0;
		tdone("refusals");
		// Toggle must show while the button is still held
		btnRaw[0].centre = 1'b1;
		repeat (36) @(negedge clk);
		chk("held led", ovrLed[0], 1'b1);
		press(0, BTN_CENTRE, 4);
		autoVal[0] = 8'h99;
		toolEn[0] = 1'b1;
		toolVal[0] = 8'h77;
		repeat (2) @(negedge clk);
		chk("hold", outValue[0], 8'h40);
		press(0, BTN_PLUS, 12);
		chk("plus", outValue[0], 8'h50);
		chk("rep val", lastVal[0], 8'h50);
		chk("rep ovr", lastOvr[0], 1'b1);
		press(0, BTN_MINUS, 12);
		chk("minus", outValue[0], 8'h40);
		press(0, BTN_PLUS, 2);
		chk("glitch", outValue[0], 8'h40);
		press(0, BTN_PLUS, 200);
		chk("top", outValue[0], VAL_MAX);
		press(0, BTN_MINUS, 200);
		chk("bottom", outValue[0], VAL_MIN);
		tdone("stepping");
		press(3, BTN_CENTRE, 40);
		press(3, BTN_PLUS, 12);
		chk("relay on", outValue[3], 8'hFF);
		supplyOk = 1'b0;
		press(3, BTN_MINUS, 12);
		chk("supply err", errSeen[3], 1'b1);
		chk("supply val", outValue[3], 8'hFF);
		supplyOk = 1'b1;
		press(3, BTN_MINUS, 12);
		chk("relay off", outValue[3], 8'h00);
		press(0, BTN_CENTRE, 40);
		chk("exit led", ovrLed[0], 1'b0);
		chk("exit val", outValue[0], 8'h77);
		chk("exit rep", lastOvr[0], 1'b0);
		tdone("relay and exit");
		groupMask = 4'h3;
		press(1, BTN_CENTRE, 40);
		chk("group leds", ovrLed[1:0], 2'h3);
		press(0, BTN_PLUS, 12);
		chk("group p0", outValue[0], 8'h87);
		chk("group p1", outValue[1], 8'h40);
		tdone("group");
		// Retained entries come back after a second reset
		restoreEn = 1'b1;
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		chk("mid reset", ovrLed, 4'h0);
		sys_rst = 1'b0;
		repeat (20) @(negedge clk);
		chk("restore leds", ovrLed, 4'hB);
		chk("restore p0", outValue[0], 8'h87);
		chk("restore p1", outValue[1], 8'h40);
		chk("restore p3", outValue[3], 8'h00);
		chk("restore reps", nReport, 8'h04);
		chk("restore rep0", lastVal[0], 8'h87);
		tdone("restore");
		final_report();
	end
endmodule
bind io_point_local_override io_point_local_override_sva i_sva (
	.clk(clk), .sys_rst(sys_rst), .isOutput(isOutput),
	.ovrDisable(ovrDisable), .toolEn(toolEn), .testEn(testEn),
	.autoVal(autoVal), .toolVal(toolVal), .testVal(testVal),
	.outValue(outValue), .ovrLed(ovrLed), .statusLed(statusLed),
	.lcdValue(lcdValue), .lcdUpdate(lcdUpdate), .errInd(errInd),
	.report(report));
`default_nettype wire
